// ### rtl/uabrk_top.sv
// uabrk_top: asynchronous serial port with baud generator, auto-baud,
// two-entry receive buffer and break transmission.
// assumes rx_in synchronous to mclk_in and a register master that never
// issues read and write strobes together.
// Operation
// - mode bit 3 set selects high-speed baud, clear selects low-speed.
// - high-speed reception works for every divisor value including zero.
// - auto-baud divides the measurement with high-speed scaling when selected.
// - writing one to autobaud_enable starts measuring and loads the divisor.
// - sender transmits 0x55; device consumes it and never buffers it.
// - with divisor 0x0000 or 0xffff the sync character is still not buffered.
// - one receive pulse after the sync character, none at its start bit.
// - rx_data_available, status bit 0, is set exactly while data is buffered.
// - auto-baud result is rounded to the nearest divisor rather than truncated.
// - a queued break sends a long low instead of its dummy character.
// - consecutive breaks each send as break; a following character sends normally.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
module uabrk_top #(
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [15:0] rd_data_out,
  // serial line
  input  wire logic        rx_in,
  output logic             tx_out,
  // receive event
  output logic             rx_irq_out
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("uabrk_top: DEPTH must be a power of two, at least 2");
  end

  // register state
  logic [15:0]            mode_reg;
  logic [15:0]            div_reg;
  logic                   ovr_reg;
  logic                   ferr_reg;
  logic [15:0]            rd_data_reg;
  // baud tick
  logic [15:0]            tick_cnt_reg;
  // receiver
  uabrk_pkg::uabrk_rx_state_t rx_state_reg;
  logic [3:0]             rx_os_reg;
  logic [3:0]             rx_bit_reg;
  logic [7:0]             rx_shift_reg;
  logic                   rx_prev_reg;
  // buffer
  logic [7:0]             buf_mem_reg [DEPTH];
  logic [PTR_W-1:0]       wr_ptr_reg;
  logic [PTR_W-1:0]       rd_ptr_reg;
  logic [PTR_W:0]         count_reg;
  // transmitter
  uabrk_pkg::uabrk_tx_state_t tx_state_reg;
  logic [3:0]             tx_os_reg;
  logic [3:0]             tx_bit_reg;
  logic [7:0]             tx_shift_reg;
  logic                   tx_line_reg;
  logic [7:0]             hold_data_reg;
  logic                   hold_brk_reg;
  logic                   hold_valid_reg;
  logic                   hold_brk_sent_reg;
  // auto-baud
  uabrk_pkg::uabrk_ab_state_t ab_state_reg;
  logic [uabrk_pkg::AB_CNT_W-1:0] ab_cnt_reg;
  logic [2:0]             ab_falls_reg;
  logic                   irq_reg;

  // decode
  wire high_speed_select = mode_reg[uabrk_pkg::MODE_HS_BIT];
  wire autobaud_enable   = mode_reg[uabrk_pkg::MODE_AB_BIT];
  wire wr_mode = wr_en_in && (addr_in == uabrk_pkg::MODE_OFS);
  wire wr_stat = wr_en_in && (addr_in == uabrk_pkg::STAT_OFS);
  wire wr_div  = wr_en_in && (addr_in == uabrk_pkg::DIV_OFS);
  wire wr_txd  = wr_en_in && (addr_in == uabrk_pkg::TXD_OFS);
  wire rd_rxd  = rd_en_in && (addr_in == uabrk_pkg::RXD_OFS);

  // ticks per bit follow the speed select
  wire [3:0] os_max = high_speed_select ? uabrk_pkg::OS_HIGH_MAX : uabrk_pkg::OS_LOW_MAX;
  wire [3:0] os_half = {1'b0, os_max[3:1]};

  // baud tick: one pulse every divisor+1 clocks; divisor zero ticks each clock
  wire baud_tick = (tick_cnt_reg == 16'h0000);

  wire rx_fall = rx_prev_reg && !rx_in;

  // buffer handshake, filling and draining sides
  wire              push_valid;
  wire              push_ready = (count_reg != (PTR_W+1)'(DEPTH));
  wire              pop_valid  = (count_reg != '0);
  wire              pop_ready  = rd_rxd;
  wire              push_fire  = push_valid && push_ready;
  wire              pop_fire   = pop_valid && pop_ready;
  wire [PTR_W:0]    count_next = count_reg + {{PTR_W{1'b0}}, push_fire}
                                 - {{PTR_W{1'b0}}, pop_fire};

  // receiver timing; the receiver stands aside while auto-baud owns the line
  wire rx_active  = !autobaud_enable && (ab_state_reg == uabrk_pkg::AB_IDLE);
  wire rx_os_end  = baud_tick && (rx_os_reg == os_max);
  wire rx_os_mid  = baud_tick && (rx_os_reg == os_half);
  wire rx_stop_ok = rx_os_end && (rx_state_reg == uabrk_pkg::RX_STOP) && rx_in;
  wire rx_stop_bad = rx_os_end && (rx_state_reg == uabrk_pkg::RX_STOP) && !rx_in;
  // sampling only compares tick counts, so any divisor is served
  assign push_valid = rx_stop_ok;

  uabrk_pkg::uabrk_rx_state_t rx_state_next;
  always_comb begin
    rx_state_next = rx_state_reg;
    unique case (rx_state_reg)
      uabrk_pkg::RX_IDLE:  if (rx_active && rx_fall) begin
        rx_state_next = uabrk_pkg::RX_START;
      end
      uabrk_pkg::RX_START: if (rx_os_mid) begin
        rx_state_next = rx_in ? uabrk_pkg::RX_IDLE : uabrk_pkg::RX_DATA;
      end
      uabrk_pkg::RX_DATA:  if (rx_os_end && rx_bit_reg == uabrk_pkg::DATA_BITS - 4'h1) begin
        rx_state_next = uabrk_pkg::RX_STOP;
      end
      uabrk_pkg::RX_STOP:  if (rx_os_end) begin
        rx_state_next = uabrk_pkg::RX_IDLE;
      end
    endcase
  end

  wire rx_restart = (rx_state_reg == uabrk_pkg::RX_IDLE)
                    || (rx_state_reg == uabrk_pkg::RX_START && rx_os_mid);
  wire [3:0] rx_os_next  = rx_restart ? 4'h0 :
                           (baud_tick ? (rx_os_end ? 4'h0 : rx_os_reg + 4'h1) : rx_os_reg);
  wire [3:0] rx_bit_next = (rx_state_reg != uabrk_pkg::RX_DATA) ? 4'h0 :
                           (rx_os_end ? rx_bit_reg + 4'h1 : rx_bit_reg);
  wire rx_sample = rx_os_end && (rx_state_reg == uabrk_pkg::RX_DATA);

  // auto-baud: count clocks from the first to the fifth falling edge (8 bits)
  localparam logic [2:0] SYNC_LAST = uabrk_pkg::SYNC_FALLS - 3'h1;
  wire ab_fall_last = rx_fall && (ab_falls_reg == SYNC_LAST);
  // high-speed scaling divides by 8x4, low-speed by 8x16
  // half the divisor step is added so the result rounds to nearest
  wire [uabrk_pkg::AB_CNT_W-1:0] ab_scaled = high_speed_select ?
    ((ab_cnt_reg + (25'd1 << (uabrk_pkg::AB_SHIFT_HIGH - 1))) >> uabrk_pkg::AB_SHIFT_HIGH) :
    ((ab_cnt_reg + (25'd1 << (uabrk_pkg::AB_SHIFT_LOW - 1))) >> uabrk_pkg::AB_SHIFT_LOW);
  wire [15:0] ab_div = (ab_scaled == '0) ? 16'h0000 :
                       (ab_scaled > 25'h10000) ? 16'hffff :
                       ab_scaled[15:0] - 16'h0001;
  wire ab_done = (ab_state_reg == uabrk_pkg::AB_WAIT_STOP) && rx_in;

  uabrk_pkg::uabrk_ab_state_t ab_state_next;
  always_comb begin
    ab_state_next = ab_state_reg;
    unique case (ab_state_reg)
      uabrk_pkg::AB_IDLE:      if (autobaud_enable) begin
        ab_state_next = uabrk_pkg::AB_WAIT_EDGE;
      end
      uabrk_pkg::AB_WAIT_EDGE: if (rx_fall) begin
        ab_state_next = uabrk_pkg::AB_MEASURE;
      end
      uabrk_pkg::AB_MEASURE:   if (ab_fall_last) begin
        ab_state_next = uabrk_pkg::AB_WAIT_STOP;
      end
      uabrk_pkg::AB_WAIT_STOP: if (rx_in) begin
        ab_state_next = uabrk_pkg::AB_IDLE;
      end
    endcase
  end

  // the span is held through the last low bit, the divisor is taken at the stop bit
  wire [uabrk_pkg::AB_CNT_W-1:0] ab_cnt_next =
    (ab_state_reg == uabrk_pkg::AB_WAIT_STOP) ? ab_cnt_reg :
    (ab_state_reg != uabrk_pkg::AB_MEASURE) ? '0 :
    (&ab_cnt_reg ? ab_cnt_reg : ab_cnt_reg + 25'd1);
  wire [2:0] ab_falls_next = (ab_state_reg == uabrk_pkg::AB_WAIT_EDGE) ? 3'h1 :
                             (ab_state_reg == uabrk_pkg::AB_MEASURE && rx_fall) ?
                             ab_falls_reg + 3'h1 : ab_falls_reg;

  // mode register: software write, then self-clear of the enable on completion
  wire tx_take_ok = !hold_valid_reg;
  logic [15:0] mode_next;
  always_comb begin
    mode_next = wr_mode ? wr_data_in : mode_reg;
    // enable drops when the measured divisor is stored
    if (ab_done && !wr_mode) begin
      mode_next[uabrk_pkg::MODE_AB_BIT] = 1'b0;
    end
    // break request is consumed by the character that carries it
    if (wr_txd && tx_take_ok && !wr_mode) begin
      mode_next[uabrk_pkg::MODE_BRK_BIT] = 1'b0;
    end
  end

  // measured divisor overrides the software value
  wire [15:0] div_next = ab_done ? ab_div : (wr_div ? wr_data_in : div_reg);

  // restart on any new divisor, so a stale long count never delays the new rate
  wire [15:0] tick_cnt_next = (baud_tick || wr_div || ab_done) ? div_next :
                              tick_cnt_reg - 16'h0001;

  // transmitter holding entry; a write while full is dropped
  wire tx_load    = (tx_state_reg == uabrk_pkg::TX_IDLE) && hold_valid_reg;
  wire tx_os_end  = baud_tick && (tx_os_reg == os_max);
  wire tx_bit_end = tx_os_end && (tx_bit_reg == ((tx_state_reg == uabrk_pkg::TX_BREAK) ?
                    uabrk_pkg::BRK_BITS - 4'h2 : uabrk_pkg::DATA_BITS - 4'h1));

  uabrk_pkg::uabrk_tx_state_t tx_state_next;
  always_comb begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      uabrk_pkg::TX_IDLE:  if (tx_load) begin
        tx_state_next = uabrk_pkg::TX_START;
      end
      // a break entry skips the data bits and stays low instead
      uabrk_pkg::TX_START: if (tx_os_end) begin
        tx_state_next = hold_brk_sent_reg ? uabrk_pkg::TX_BREAK : uabrk_pkg::TX_DATA;
      end
      uabrk_pkg::TX_DATA:  if (tx_bit_end) begin
        tx_state_next = uabrk_pkg::TX_STOP;
      end
      uabrk_pkg::TX_BREAK: if (tx_bit_end) begin
        tx_state_next = uabrk_pkg::TX_STOP;
      end
      uabrk_pkg::TX_STOP:  if (tx_os_end) begin
        tx_state_next = uabrk_pkg::TX_IDLE;
      end
    endcase
  end

  wire [3:0] tx_os_next  = (tx_state_reg == uabrk_pkg::TX_IDLE) ? 4'h0 :
                           (baud_tick ? (tx_os_end ? 4'h0 : tx_os_reg + 4'h1) : tx_os_reg);
  wire bit_state = (tx_state_reg == uabrk_pkg::TX_DATA) || (tx_state_reg == uabrk_pkg::TX_BREAK);
  wire [3:0] tx_bit_next = !bit_state ? 4'h0 : (tx_os_end ? tx_bit_reg + 4'h1 : tx_bit_reg);
  wire tx_line_next = (tx_state_next == uabrk_pkg::TX_START) ? 1'b0 :
                      (tx_state_next == uabrk_pkg::TX_BREAK) ? 1'b0 :
                      (tx_state_next == uabrk_pkg::TX_DATA) ?
                      ((tx_state_reg == uabrk_pkg::TX_START) ? tx_shift_reg[0] :
                       (tx_os_end ? tx_shift_reg[1] : tx_shift_reg[0])) : 1'b1;

  // read mux
  wire [15:0] stat_word = {10'h000, ferr_reg, (ab_state_reg != uabrk_pkg::AB_IDLE),
                           (tx_state_reg == uabrk_pkg::TX_IDLE) && !hold_valid_reg,
                           hold_valid_reg, ovr_reg, pop_valid};
  // available flag is the buffer's own non-empty state
  wire [15:0] rd_mux = (addr_in == uabrk_pkg::MODE_OFS) ? mode_reg :
                       (addr_in == uabrk_pkg::STAT_OFS) ? stat_word :
                       (addr_in == uabrk_pkg::DIV_OFS)  ? div_reg :
                       (addr_in == uabrk_pkg::RXD_OFS)  ?
                       {8'h00, pop_valid ? buf_mem_reg[rd_ptr_reg] : 8'h00} : 16'h0000;

  // registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_reg     <= uabrk_pkg::MODE_RST;
      div_reg      <= uabrk_pkg::DIV_RST;
      tick_cnt_reg <= uabrk_pkg::DIV_RST;
      rd_data_reg  <= 16'h0000;
    end else begin
      mode_reg     <= mode_next;
      div_reg      <= div_next;
      tick_cnt_reg <= tick_cnt_next;
      rd_data_reg  <= rd_en_in ? rd_mux : 16'h0000;
    end
  end

  // sticky flags: a new event in the clearing cycle wins
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ovr_reg  <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      ovr_reg  <= (push_valid && !push_ready)
                  || (ovr_reg && !(wr_stat && wr_data_in[uabrk_pkg::STAT_OVR_BIT]));
      ferr_reg <= rx_stop_bad
                  || (ferr_reg && !(wr_stat && wr_data_in[uabrk_pkg::STAT_FERR_BIT]));
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_state_reg <= uabrk_pkg::RX_IDLE;
      rx_os_reg    <= 4'h0;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_prev_reg  <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_os_reg    <= rx_os_next;
      rx_bit_reg   <= rx_bit_next;
      rx_shift_reg <= rx_sample ? {rx_in, rx_shift_reg[7:1]} : rx_shift_reg;
      rx_prev_reg  <= rx_in;
    end
  end

  // two-entry buffer; the sync character never reaches it
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PTR_W'(push_fire);
      rd_ptr_reg <= rd_ptr_reg + PTR_W'(pop_fire);
      count_reg  <= count_next;
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_buf
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          buf_mem_reg[i] <= 8'h00;
        end else if (push_fire && wr_ptr_reg == PTR_W'(i)) begin
          buf_mem_reg[i] <= rx_shift_reg;
        end
      end
    end
  endgenerate

  // the measuring engine has no path into the buffer
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ab_state_reg <= uabrk_pkg::AB_IDLE;
      ab_cnt_reg   <= '0;
      ab_falls_reg <= 3'h0;
    end else begin
      ab_state_reg <= ab_state_next;
      ab_cnt_reg   <= ab_cnt_next;
      ab_falls_reg <= ab_falls_next;
    end
  end

  // one pulse per character: at sync completion or on each buffered byte
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= ab_done || push_fire;
    end
  end

  // each entry carries its own break mark, so breaks can follow breaks
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_data_reg  <= 8'h00;
      hold_brk_reg   <= 1'b0;
      hold_valid_reg <= 1'b0;
      hold_brk_sent_reg <= 1'b0;
    end else begin
      if (wr_txd && tx_take_ok) begin
        hold_data_reg  <= wr_data_in[7:0];
        hold_brk_reg   <= mode_reg[uabrk_pkg::MODE_BRK_BIT];
        hold_valid_reg <= 1'b1;
      end else if (tx_load) begin
        hold_valid_reg <= 1'b0;
      end
      if (tx_load) begin
        hold_brk_sent_reg <= hold_brk_reg;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_state_reg <= uabrk_pkg::TX_IDLE;
      tx_os_reg    <= 4'h0;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 8'h00;
      tx_line_reg  <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_os_reg    <= tx_os_next;
      tx_bit_reg   <= tx_bit_next;
      // the dummy byte of a break is never shifted onto the line
      if (tx_load) begin
        tx_shift_reg <= hold_brk_reg ? 8'h00 : hold_data_reg;
      end else if (tx_os_end && tx_state_reg == uabrk_pkg::TX_DATA) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
      end
      tx_line_reg  <= tx_line_next;
    end
  end

  assign rd_data_out = rd_data_reg;
  assign tx_out      = tx_line_reg;
  assign rx_irq_out  = irq_reg;

endmodule // uabrk_top

// ### include/uabrk_pkg.sv
// uabrk_pkg: register map, field positions, reset values and fixed counts
// of the serial port with auto-baud and break support.
// assumes a byte-addressed register port with 16-bit data words.
package uabrk_pkg;

  // register byte offsets
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] DIV_OFS  = 8'h08;
  localparam logic [7:0] TXD_OFS  = 8'h0c;
  localparam logic [7:0] RXD_OFS  = 8'h10;

  // serial_mode_register fields
  localparam int unsigned MODE_HS_BIT  = 3;
  localparam int unsigned MODE_AB_BIT  = 5;
  localparam int unsigned MODE_BRK_BIT = 8;

  // serial_status_register fields
  localparam int unsigned STAT_RXDA_BIT   = 0;
  localparam int unsigned STAT_OVR_BIT    = 1;
  localparam int unsigned STAT_TXFULL_BIT = 2;
  localparam int unsigned STAT_TXIDLE_BIT = 3;
  localparam int unsigned STAT_ABBUSY_BIT = 4;
  localparam int unsigned STAT_FERR_BIT   = 5;

  // reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] DIV_RST  = 16'h0000;

  // oversampling: ticks per bit minus one, low and high speed
  localparam logic [3:0] OS_LOW_MAX  = 4'hf;
  localparam logic [3:0] OS_HIGH_MAX = 4'h3;

  // sync character and its measurement: 5 falling edges span 8 bit times
  localparam logic [7:0]  SYNC_CHAR     = 8'h55;
  localparam logic [2:0]  SYNC_FALLS    = 3'h5;
  localparam int unsigned AB_CNT_W      = 25;
  localparam int unsigned AB_SHIFT_LOW  = 7;
  localparam int unsigned AB_SHIFT_HIGH = 5;

  // break: line held low for this many bit times before the stop bit
  localparam logic [3:0] BRK_BITS = 4'hd;
  localparam logic [3:0] DATA_BITS = 4'h8;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} uabrk_rx_state_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_BREAK, TX_STOP} uabrk_tx_state_t;
  typedef enum {AB_IDLE, AB_WAIT_EDGE, AB_MEASURE, AB_WAIT_STOP} uabrk_ab_state_t;

endpackage : uabrk_pkg

// ### test/uabrk_checker.sv
// uabrk_checker: port-level checks of uabrk_top, bound into every instance.
// assumes one-cycle strobes and read data only in the cycle after a read.
module uabrk_checker #(
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  input  wire logic [15:0] rd_data_out,
  // serial and event
  input  wire logic        rx_in,
  input  wire logic        tx_out,
  input  wire logic        rx_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  wire addr_mapped = (addr_in == uabrk_pkg::MODE_OFS) || (addr_in == uabrk_pkg::STAT_OFS) ||
                     (addr_in == uabrk_pkg::DIV_OFS) || (addr_in == uabrk_pkg::TXD_OFS) ||
                     (addr_in == uabrk_pkg::RXD_OFS);

  sequence s_wr(a);
    wr_en_in && addr_in == a;
  endsequence
  sequence s_rd(a);
    rd_en_in && addr_in == a;
  endsequence

  a_rd_data_idle: assert property (!rd_en_in |=> rd_data_out == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rd_en_in && !addr_mapped |=> rd_data_out == 16'h0000)
    else $error("unmapped read not zero");
  a_rxd_upper_zero: assert property (s_rd(uabrk_pkg::RXD_OFS) |=> rd_data_out[15:8] == 8'h00)
    else $error("receive data upper byte not zero");
  a_stat_upper_zero: assert property (s_rd(uabrk_pkg::STAT_OFS) |=> rd_data_out[15:6] == 0)
    else $error("status unused bits not zero");
  a_div_readback: assert property (
    s_wr(uabrk_pkg::DIV_OFS) ##2 s_rd(uabrk_pkg::DIV_OFS) |=> rd_data_out == $past(wr_data_in, 3))
    else $error("divisor readback differs");
  a_mode_speed_bit: assert property (
    s_wr(uabrk_pkg::MODE_OFS) ##2 s_rd(uabrk_pkg::MODE_OFS)
    |=> ((rd_data_out ^ $past(wr_data_in, 3)) & 16'h0008) == 16'h0000)
    else $error("speed select readback differs");
  // a frame is far longer than eight cycles, so events never crowd
  a_irq_one_pulse: assert property (rx_irq_out |=> !rx_irq_out [*8])
    else $error("receive event pulses too close");
  a_irq_after_high: assert property (rx_irq_out |-> $past(rx_in) || $past(rx_in, 2))
    else $error("receive event while line low");
endmodule // uabrk_checker

bind uabrk_top uabrk_checker #(.DEPTH(DEPTH)) u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .rx_in(rx_in),
  .tx_out(tx_out), .rx_irq_out(rx_irq_out)
);

// ### test/uabrk_remote.sv
// uabrk_remote: far-end serial sender and receiver, 8N1, LSB first.
// assumes its line changes only just after a rising clock edge.
module uabrk_remote (
  // clock
  input  wire logic mclk_in,
  // serial lines
  input  wire logic tx_line_in,
  output logic      rx_line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned tx_bit_clks = 32;
  logic [8:0]  got_q[$];

  initial rx_line_out = 1'b1;

  task automatic send_byte(input logic [7:0] b, input int unsigned clks);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line_out <= frame[i];
      repeat (clks) @(posedge mclk_in);
    end
  endtask

  // a break shows as a line still low at the stop sample; logged as 0x100
  always begin : rx_frames
    logic [7:0] d;
    @(negedge tx_line_in);
    repeat (tx_bit_clks / 2) @(posedge mclk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (tx_bit_clks) @(posedge mclk_in);
      d[i] = tx_line_in;
    end
    repeat (tx_bit_clks) @(posedge mclk_in);
    if (tx_line_in !== 1'b1) begin
      got_q.push_back(9'h100);
      while (tx_line_in !== 1'b1) @(posedge mclk_in);
    end else got_q.push_back({1'b0, d});
  end
endmodule // uabrk_remote

// ### test/uabrk_top_test.sv
// uabrk_top_test: self-checking bench for uabrk_top with a far-end model.
// assumes the package is compiled first; clock 25 MHz.
module uabrk_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in = 1'b0;
  logic        rst_n_in, wr_en_in, rd_en_in, rx_line, tx_out, rx_irq_out;
  logic [7:0]  addr_in;
  logic [15:0] wr_data_in, rd_data_out;
  int          n_fail = 0;
  int          n_compared = 0;
  int          n_irq = 0;

  uabrk_top dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .rx_in(rx_line), .tx_out(tx_out), .rx_irq_out(rx_irq_out));
  uabrk_remote u_remote (.mclk_in(mclk_in), .tx_line_in(tx_out), .rx_line_out(rx_line));

  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) if (rx_irq_out === 1'b1) n_irq++;

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge mclk_in);
    wr_en_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge mclk_in);
    rd_en_in <= 1'b0;
    @(posedge mclk_in);
    d = rd_data_out;
  endtask
  task automatic wait_stat(input int unsigned bitn, input logic val);
    logic [15:0] s;
    for (int i = 0; i < 2000; i++) begin
      rd(uabrk_pkg::STAT_OFS, s);
      if (s[bitn] === val) return;
    end
    n_fail++;
    $display("Error status bit %0d expected %b seen %b", bitn, val, s[bitn]);
    final_report();
  endtask
  // counts events over the whole frame, so an early one at the start bit shows up
  task automatic send_wait(input logic [7:0] b, input int unsigned clks);
    int base;
    base = n_irq;
    u_remote.send_byte(b, clks);
    for (int i = 0; i < 64 && n_irq == base; i++) @(posedge mclk_in);
    check("rx events", 16'(n_irq - base), 16'h0001);
    if (n_irq == base) final_report();
  endtask

  task automatic t_reset();
    logic [15:0] v;
    check("tx idle", {15'h0000, tx_out}, 16'h0001);
    rd(uabrk_pkg::MODE_OFS, v);
    check("mode reset", v, uabrk_pkg::MODE_RST);
    rd(uabrk_pkg::DIV_OFS, v);
    check("divisor reset", v, uabrk_pkg::DIV_RST);
    rd(uabrk_pkg::STAT_OFS, v);
    check("data available", {15'h0000, v[0]}, 16'h0000);
    rd(8'h14, v);
    check("unmapped", v, 16'h0000);
  endtask

  task automatic t_receive(input logic hs, input logic [15:0] div, input logic [7:0] b);
    logic [15:0] v;
    int unsigned clks;
    clks = (div + 1) * (hs ? 4 : 16);
    wr(uabrk_pkg::DIV_OFS, div);
    rd(uabrk_pkg::DIV_OFS, v);
    check("divisor", v, div);
    wr(uabrk_pkg::MODE_OFS, {12'h000, hs, 3'h0});
    rd(uabrk_pkg::MODE_OFS, v);
    check("mode", v, {12'h000, hs, 3'h0});
    send_wait(b, clks);
    send_wait(~b, clks);
    u_remote.send_byte(8'h00, clks);
    wait_stat(uabrk_pkg::STAT_OVR_BIT, 1'b1);
    rd(uabrk_pkg::STAT_OFS, v);
    check("data available full", {15'h0000, v[0]}, 16'h0001);
    rd(uabrk_pkg::RXD_OFS, v);
    check("rx byte 0", v, {8'h00, b});
    rd(uabrk_pkg::RXD_OFS, v);
    check("rx byte 1", v, {8'h00, ~b});
    rd(uabrk_pkg::STAT_OFS, v);
    check("data available empty", {15'h0000, v[0]}, 16'h0000);
    wr(uabrk_pkg::STAT_OFS, 16'h0022);
  endtask

  task automatic t_autobaud(input logic hs, input int unsigned bclk, input logic [15:0] init);
    logic [15:0] v, exp;
    int unsigned den;
    den = hs ? 32 : 128;
    exp = 16'((8 * bclk + den / 2) / den - 1);
    wr(uabrk_pkg::DIV_OFS, init);
    wr(uabrk_pkg::MODE_OFS, {10'h000, 1'b1, 1'b0, hs, 3'h0});
    rd(uabrk_pkg::STAT_OFS, v);
    check("autobaud busy", {15'h0000, v[uabrk_pkg::STAT_ABBUSY_BIT]}, 16'h0001);
    send_wait(uabrk_pkg::SYNC_CHAR, bclk);
    rd(uabrk_pkg::DIV_OFS, v);
    check("measured divisor", v, exp);
    rd(uabrk_pkg::MODE_OFS, v);
    check("autobaud enable", {15'h0000, v[uabrk_pkg::MODE_AB_BIT]}, 16'h0000);
    rd(uabrk_pkg::STAT_OFS, v);
    check("sync not buffered", {15'h0000, v[0]}, 16'h0000);
    send_wait(8'h96, (exp + 1) * (hs ? 4 : 16));
    rd(uabrk_pkg::RXD_OFS, v);
    check("rx at measured rate", v, 16'h0096);
  endtask

  task automatic t_break();
    logic [15:0] v;
    wr(uabrk_pkg::DIV_OFS, 16'h0001);
    wr(uabrk_pkg::MODE_OFS, 16'h0000);
    u_remote.tx_bit_clks = 32;
    u_remote.got_q.delete();
    for (int k = 0; k < 2; k++) begin
      wait_stat(uabrk_pkg::STAT_TXFULL_BIT, 1'b0);
      wr(uabrk_pkg::MODE_OFS, 16'h0100);
      wr(uabrk_pkg::TXD_OFS, 16'h003c);
    end
    wait_stat(uabrk_pkg::STAT_TXFULL_BIT, 1'b0);
    wr(uabrk_pkg::TXD_OFS, 16'h005a);
    rd(uabrk_pkg::STAT_OFS, v);
    check("tx busy", {15'h0000, v[uabrk_pkg::STAT_TXIDLE_BIT]}, 16'h0000);
    for (int i = 0; i < 4000 && u_remote.got_q.size() < 3; i++) @(posedge mclk_in);
    check("tx frames", 16'(u_remote.got_q.size()), 16'h0003);
    if (u_remote.got_q.size() < 3) final_report();
    check("frame 0", 16'(u_remote.got_q[0]), 16'h0100);
    check("frame 1", 16'(u_remote.got_q[1]), 16'h0100);
    check("frame 2", 16'(u_remote.got_q[2]), 16'h005a);
    wait_stat(uabrk_pkg::STAT_TXIDLE_BIT, 1'b1);
    check("tx line idle", {15'h0000, tx_out}, 16'h0001);
  endtask

  initial begin
    rst_n_in = 1'b0;
    addr_in = 8'h00;
    wr_data_in = 16'h0000;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    repeat (6) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_receive(1'b1, 16'h0000, 8'ha3);
    t_receive(1'b1, 16'h0002, 8'h71);
    t_receive(1'b0, 16'h0001, 8'hc5);
    t_autobaud(1'b0, 56, 16'hffff);
    t_autobaud(1'b1, 22, 16'h0000);
    t_break();
    final_report();
  end
endmodule // uabrk_top_test
